// *** verilog/supervisor_fault_timing_pkg.sv ***
// Timing constants and state type for the supervisor sequencing block
`default_nettype none
package supervisor_fault_timing_pkg;
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned CYC_PER_US     = 1000 / CLK_PERIOD_NS;
    localparam int unsigned NUM_CH         = 8;
    localparam int unsigned FILT_W         = 10;
    // Start-up times in microseconds
    localparam int unsigned LOAD_US        = 2000;
    localparam int unsigned READY_BUILTIN_SELFTEST_US  = 12000;
    localparam int unsigned SELFTEST_US    = 10000;
    localparam int unsigned LOAD_CYC       = LOAD_US * CYC_PER_US;
    localparam int unsigned READY_BUILTIN_SELFTEST_CYC = READY_BUILTIN_SELFTEST_US * CYC_PER_US;
    localparam int unsigned SELFTEST_CYC   = SELFTEST_US * CYC_PER_US;
    // Sequence stamp: step in microseconds, range in seconds
    localparam int unsigned STEP_US        = 50;
    localparam int unsigned SEQ_RANGE_S    = 4;
    localparam int unsigned STEP_CYC       = STEP_US * CYC_PER_US;
    localparam int unsigned STAMP_MAX      = SEQ_RANGE_S * 1000000 / STEP_US;
    localparam int unsigned STAMP_W        = 17;
    localparam int unsigned PRE_W          = 9;
    // Latency bounds in microseconds
    localparam int unsigned MON_ACT_US     = 10;
    localparam int unsigned MON_ACT_CYC    = MON_ACT_US * CYC_PER_US;
    localparam int unsigned FAULT_LAT_US   = 25;
    localparam int unsigned FAULT_LAT_CYC  = FAULT_LAT_US * CYC_PER_US;
    // Reset release delay per 3-bit code, microseconds
    localparam int unsigned RST_DLY_US [8] = '{200, 1000, 10000, 16000, 20000, 70000, 100000, 200000};
    localparam int unsigned DLY_W          = 21;
    localparam int unsigned TMR_W          = 17;
    localparam logic [2:0]  RST_DLY_DEF    = 3'h0;
    typedef enum logic [1:0] {ST_LOAD, ST_TEST, ST_READY} seq_state_t;
endpackage : supervisor_fault_timing_pkg
`default_nettype wire

// *** verilog/supervisor_fault_timing.sv ***
// Start-up sequencer, sequence stamp, fault filters and fault outputs
//
// Overview of operation
// - With power-up test: ready within 12 ms
// - Without power-up test: ready within 2 ms
// - Self-test finishes within 10 ms
// - Serial bus enabled when self-test completes
// - Stamp starts on edge, 50 us steps
// - Monitoring active within 10 us of activity
// - Other faults drive interrupt low within 25 us
// - Other faults drive reset low within 25 us
// - Default filter fast fault reaches outputs quickly
// - 3-bit code selects reset release delay
// - Per channel fast fault filter, 0.1-102.4 us
// - Bus clock and data suppress 50 ns spikes
// - Target on bus up to 1 MHz
`default_nettype none
module supervisor_fault_timing #(
    parameter int unsigned LOAD_CYC     = supervisor_fault_timing_pkg::LOAD_CYC,
    parameter int unsigned SELFTEST_CYC = supervisor_fault_timing_pkg::SELFTEST_CYC,
    parameter int unsigned RST_DLY_CYC [8] = '{
        supervisor_fault_timing_pkg::RST_DLY_US[0] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[1] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[2] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[3] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[4] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[5] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[6] * supervisor_fault_timing_pkg::CYC_PER_US,
        supervisor_fault_timing_pkg::RST_DLY_US[7] * supervisor_fault_timing_pkg::CYC_PER_US}
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        selftest_on_powerup,
    input  wire logic        selftest_on_shutdown,
    input  wire logic        activity_enable_in,
    input  wire logic        sleep_in_n,
    input  wire logic [7:0]  fast_fault_in,
    input  wire logic [79:0] fast_fault_filter_setting,
    input  wire logic        other_fault_in,
    input  wire logic [7:0]  reset_map,
    input  wire logic [2:0]  reset_delay_sel,
    input  wire logic        irq_clear,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             scl_filt,
    output logic             sda_filt,
    output logic             bus_enable,
    output logic             ready,
    output logic             selftest_busy,
    output logic             monitor_active,
    output logic [7:0]       fast_fault_filt,
    output logic [16:0]      sequence_stamp,
    output logic             fault_irq_out_n,
    output logic             fault_irq_oe,
    output logic             sys_reset_out_n,
    output logic             sys_reset_oe
);
    localparam int unsigned NCH  = supervisor_fault_timing_pkg::NUM_CH;
    localparam int unsigned SW   = supervisor_fault_timing_pkg::STAMP_W;
    localparam int unsigned TW   = supervisor_fault_timing_pkg::TMR_W;
    localparam int unsigned DW   = supervisor_fault_timing_pkg::DLY_W;
    localparam int unsigned PW   = supervisor_fault_timing_pkg::PRE_W;
    localparam int unsigned FW   = supervisor_fault_timing_pkg::FILT_W;
    localparam int unsigned SYNW = NCH + 5;

    // Two-stage synchronisers for the bus, sleep, activity and fault pins; stage one feeds stage two only
    logic [SYNW-1:0] sync1_r;
    logic [SYNW-1:0] sync2_r;
    logic [SYNW-1:0] sync3_r;
    // Bus lines and sleep idle high; a zero reset would fake an edge at release
    localparam logic [SYNW-1:0] SYNC_IDLE = {3'b111, {(SYNW - 3){1'b0}}};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_r <= SYNC_IDLE;
            sync2_r <= SYNC_IDLE;
            sync3_r <= SYNC_IDLE;
        end else begin
            sync1_r <= {scl_in, sda_in, sleep_in_n, activity_enable_in, other_fault_in, fast_fault_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    logic       act_s;
    logic       act_d;
    logic       sleep_s;
    logic       sleep_d;
    logic       other_s;
    logic [7:0] fast_s;
    assign fast_s  = sync2_r[NCH-1:0];
    assign other_s = sync2_r[NCH];
    assign act_s   = sync2_r[NCH+1];
    assign act_d   = sync3_r[NCH+1];
    assign sleep_s = sync2_r[NCH+2];
    assign sleep_d = sync3_r[NCH+2];

    // Bus spike filter: a level must hold two samples (200 ns) to pass
    logic scl_f_r;
    logic scl_f_nxt;
    logic sda_f_r;
    logic sda_f_nxt;
    always_comb begin
        scl_f_nxt = scl_f_r;
        sda_f_nxt = sda_f_r;
        if (sync2_r[SYNW-1] == sync3_r[SYNW-1]) begin
            scl_f_nxt = sync2_r[SYNW-1];
        end
        if (sync2_r[SYNW-2] == sync3_r[SYNW-2]) begin
            sda_f_nxt = sync2_r[SYNW-2];
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_f_r <= 1'b1;
            sda_f_r <= 1'b1;
        end else begin
            scl_f_r <= scl_f_nxt;
            sda_f_r <= sda_f_nxt;
        end
    end
    assign scl_filt = scl_f_r;
    assign sda_filt = sda_f_r;

    // Start-up sequencer: configuration load, optional self-test, ready
    supervisor_fault_timing_pkg::seq_state_t state_r;
    supervisor_fault_timing_pkg::seq_state_t state_nxt;
    logic [TW-1:0] tmr_r;
    logic [TW-1:0] tmr_nxt;
    always_comb begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r + 1'b1;
        case (state_r)
            supervisor_fault_timing_pkg::ST_LOAD: begin
                if (tmr_r == TW'(LOAD_CYC - 1)) begin
                    tmr_nxt   = '0;
                    state_nxt = selftest_on_powerup ? supervisor_fault_timing_pkg::ST_TEST
                                                    : supervisor_fault_timing_pkg::ST_READY;
                end
            end
            supervisor_fault_timing_pkg::ST_TEST: begin
                if (tmr_r == TW'(SELFTEST_CYC - 1)) begin
                    tmr_nxt   = '0;
                    state_nxt = supervisor_fault_timing_pkg::ST_READY;
                end
            end
            supervisor_fault_timing_pkg::ST_READY: begin
                tmr_nxt = '0;
                if (act_d && !act_s && selftest_on_shutdown) begin
                    state_nxt = supervisor_fault_timing_pkg::ST_TEST;
                end
            end
            default: begin
                state_nxt = supervisor_fault_timing_pkg::ST_LOAD;
                tmr_nxt   = '0;
            end
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= supervisor_fault_timing_pkg::ST_LOAD;
            tmr_r   <= '0;
        end else begin
            state_r <= state_nxt;
            tmr_r   <= tmr_nxt;
        end
    end
    assign ready         = (state_r == supervisor_fault_timing_pkg::ST_READY);
    assign selftest_busy = (state_r == supervisor_fault_timing_pkg::ST_TEST);
    // No wait state after the test: the bus engine is released at once
    assign bus_enable    = ready;

    // Sequence stamp; any activity or sleep edge restarts it from zero
    logic          seq_edge;
    logic          run_r;
    logic          run_nxt;
    logic [PW-1:0] pre_r;
    logic [PW-1:0] pre_nxt;
    logic [SW-1:0] stamp_r;
    logic [SW-1:0] stamp_nxt;
    assign seq_edge = (act_s != act_d) || (sleep_s != sleep_d);
    always_comb begin
        run_nxt   = run_r;
        pre_nxt   = pre_r;
        stamp_nxt = stamp_r;
        if (seq_edge) begin
            run_nxt   = 1'b1;
            pre_nxt   = '0;
            stamp_nxt = '0;
        end else if (run_r && stamp_r != SW'(supervisor_fault_timing_pkg::STAMP_MAX)) begin
            if (pre_r == PW'(supervisor_fault_timing_pkg::STEP_CYC - 1)) begin
                pre_nxt   = '0;
                stamp_nxt = stamp_r + 1'b1;
            end else begin
                pre_nxt = pre_r + 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            run_r   <= 1'b0;
            pre_r   <= '0;
            stamp_r <= '0;
        end else begin
            run_r   <= run_nxt;
            pre_r   <= pre_nxt;
            stamp_r <= stamp_nxt;
        end
    end
    assign sequence_stamp = stamp_r;

    // Monitoring follows the activity level while ready, one cycle after sync
    logic mon_r;
    logic mon_nxt;
    always_comb begin
        mon_nxt = act_s && ready;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mon_r <= 1'b0;
        end else begin
            mon_r <= mon_nxt;
        end
    end
    assign monitor_active = mon_r;

    // Per channel debounce; code n means (n+1) x 100 ns of stable level
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_filt
            logic [FW-1:0] cnt_r;
            logic [FW-1:0] cnt_nxt;
            logic          flt_r;
            logic          flt_nxt;
            logic [FW-1:0] setting;
            assign setting = fast_fault_filter_setting[gi*FW +: FW];
            always_comb begin
                cnt_nxt = '0;
                flt_nxt = flt_r;
                if ((fast_s[gi] && mon_r) != flt_r) begin
                    if (cnt_r == setting) begin
                        flt_nxt = fast_s[gi] && mon_r;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                end
            end
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    cnt_r <= '0;
                    flt_r <= 1'b0;
                end else begin
                    cnt_r <= cnt_nxt;
                    flt_r <= flt_nxt;
                end
            end
            assign fast_fault_filt[gi] = flt_r;
        end
    endgenerate

    // Interrupt latch and reset release timer
    logic          irq_n_r;
    logic          irq_n_nxt;
    logic          rst_n_r;
    logic          rst_n_nxt;
    logic [DW-1:0] dly_r;
    logic [DW-1:0] dly_nxt;
    logic          rst_fault;
    assign rst_fault = (|(fast_fault_filt & reset_map)) || other_s || !ready;
    always_comb begin
        // Set wins over a clear arriving in the same cycle
        irq_n_nxt = !((!irq_n_r && !irq_clear) || (|fast_fault_filt) || other_s);
        rst_n_nxt = rst_n_r;
        dly_nxt   = dly_r;
        if (rst_fault) begin
            rst_n_nxt = 1'b0;
            dly_nxt   = '0;
        end else if (!rst_n_r) begin
            if (dly_r == DW'(RST_DLY_CYC[reset_delay_sel] - 1)) begin
                rst_n_nxt = 1'b1;
            end else begin
                dly_nxt = dly_r + 1'b1;
            end
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_n_r <= 1'b1;
            rst_n_r <= 1'b0;
            dly_r   <= '0;
        end else begin
            irq_n_r <= irq_n_nxt;
            rst_n_r <= rst_n_nxt;
            dly_r   <= dly_nxt;
        end
    end
    assign fault_irq_out_n = irq_n_r;
    assign fault_irq_oe    = !irq_n_r;
    assign sys_reset_out_n = rst_n_r;
    assign sys_reset_oe    = !rst_n_r;

    // Checks: cycles since release, ready seen, length of the current self-test
    logic [TW-1:0] up_cnt_r;
    logic [TW-1:0] busy_cnt_r;
    logic          seen_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            up_cnt_r   <= '0;
            busy_cnt_r <= '0;
            seen_r     <= 1'b0;
        end else begin
            up_cnt_r   <= (up_cnt_r == '1) ? up_cnt_r : up_cnt_r + 1'b1;
            busy_cnt_r <= selftest_busy ? busy_cnt_r + 1'b1 : '0;
            seen_r     <= seen_r || ready;
        end
    end

    // Ready may rise on the very edge the bound is reached, before seen_r follows
    property p_ready_builtin_selftest;
        @(posedge clk) disable iff (!reset_n)
        (up_cnt_r >= TW'(LOAD_CYC + SELFTEST_CYC)) |-> seen_r || ready;
    endproperty
    a_ready_builtin_selftest: assert property (p_ready_builtin_selftest) else $error("not ready after load and self-test");

    property p_ready_nbist;
        @(posedge clk) disable iff (!reset_n)
        (up_cnt_r >= TW'(LOAD_CYC) && !selftest_on_powerup) |-> seen_r || ready;
    endproperty
    a_ready_nbist: assert property (p_ready_nbist) else $error("not ready after load");

    // Test length counted in helper logic: the full count is far too long for a delay
    property p_test_len;
        @(posedge clk) disable iff (!reset_n)
        $fell(selftest_busy) |-> ready && busy_cnt_r == TW'(SELFTEST_CYC);
    endproperty
    a_test_len: assert property (p_test_len) else $error("self-test length wrong");

    property p_stamp_step;
        @(posedge clk) disable iff (!reset_n)
        (run_r && !seq_edge && pre_r == PW'(supervisor_fault_timing_pkg::STEP_CYC - 1)
         && stamp_r != SW'(supervisor_fault_timing_pkg::STAMP_MAX)) |=> stamp_r == $past(stamp_r) + 1'b1;
    endproperty
    a_stamp_step: assert property (p_stamp_step) else $error("stamp did not step");

    property p_stamp_hold;
        @(posedge clk) disable iff (!reset_n)
        (stamp_r == SW'(supervisor_fault_timing_pkg::STAMP_MAX) && !seq_edge) |=> $stable(stamp_r);
    endproperty
    a_stamp_hold: assert property (p_stamp_hold) else $error("stamp wrapped");

    property p_mon_act;
        @(posedge clk) disable iff (!reset_n)
        ($rose(act_s) && ready) |=> monitor_active;
    endproperty
    a_mon_act: assert property (p_mon_act) else $error("monitoring late");

    property p_other_irq;
        @(posedge clk) disable iff (!reset_n)
        other_s |=> !fault_irq_out_n && !sys_reset_out_n;
    endproperty
    a_other_irq: assert property (p_other_irq) else $error("fault outputs late");

    property p_rst_release;
        @(posedge clk) disable iff (!reset_n)
        $rose(sys_reset_out_n) |-> $past(dly_r) == DW'(RST_DLY_CYC[$past(reset_delay_sel)] - 1);
    endproperty
    a_rst_release: assert property (p_rst_release) else $error("reset released early");

    property p_spike;
        @(posedge clk) disable iff (!reset_n)
        $changed(scl_filt) |-> $past(sync2_r[SYNW-1]) == $past(sync3_r[SYNW-1]);
    endproperty
    a_spike: assert property (p_spike) else $error("bus spike passed");
endmodule : supervisor_fault_timing
`default_nettype wire

// *** testbench/host_bus_model.sv ***
// Host controller model driving the two bus lines
`default_nettype none
module host_bus_model (
    output var logic scl_line,
    output var logic sda_line
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-ups hold both lines high between frames
    initial begin
        scl_line = 1'b1;
        sda_line = 1'b1;
    end
    // Start, eight bits MSB first, released ack, stop; 800 ns clock
    task automatic send_byte(input logic [7:0] b);
        logic [8:0] bits;
        bits = {b, 1'b1};
        sda_line = 1'b0;
        #400;
        for (int i = 8; i >= 0; i--) begin
            scl_line = 1'b0;
            #100 sda_line = bits[i];
            #300 scl_line = 1'b1;
            #400;
        end
        scl_line = 1'b0;
        #100 sda_line = 1'b0;
        #300 scl_line = 1'b1;
        #400 sda_line = 1'b1;
    endtask : send_byte
    // Narrow low spike on idle data line, only when the bench asks
    task automatic spike;
        sda_line = 1'b0;
        #50 sda_line = 1'b1;
    endtask : spike
endmodule : host_bus_model
`default_nettype wire

// *** testbench/supervisor_fault_timing_test.sv ***
// Self-checking bench for the supervisor sequencing block
`default_nettype none
module supervisor_fault_timing_test;
    timeunit 1ns;
    timeprecision 1ns;
    // Shortened counts keep the run to a few thousand cycles
    localparam int unsigned LOAD    = 20;
    localparam int unsigned TEST    = 30;
    localparam int unsigned DLY [8] = '{5, 8, 11, 14, 17, 20, 23, 26};
    localparam int          LIMIT   = 20000;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        selftest_on_powerup = 1'b0;
    logic        selftest_on_shutdown = 1'b0;
    logic        activity_enable_in = 1'b0;
    logic        sleep_in_n = 1'b1;
    logic [7:0]  fast_fault_in = 8'h00;
    logic [79:0] fast_fault_filter_setting = '0;
    logic        other_fault_in = 1'b0;
    logic [7:0]  reset_map = 8'h00;
    logic [2:0]  reset_delay_sel = 3'h0;
    logic        irq_clear = 1'b0;
    logic        scl_line, sda_line, scl_filt, sda_filt, bus_enable, ready, selftest_busy, monitor_active;
    logic [7:0]  fast_fault_filt;
    logic [16:0] sequence_stamp;
    logic        fault_irq_out_n, fault_irq_oe, sys_reset_out_n, sys_reset_oe;
    logic [2:0]  ch;
    logic [9:0]  code;
    logic [9:0]  sh = '0;
    logic [31:0] rnd = 32'h8102_0046;
    int          n_fail = 0;
    int          checks = 0;
    int          cyc = 0;
    int          n, edges, drops;

    supervisor_fault_timing #(.LOAD_CYC(LOAD), .SELFTEST_CYC(TEST), .RST_DLY_CYC(DLY)) u_supervisor_fault_timing (
        .clk(clk), .reset_n(reset_n), .selftest_on_powerup(selftest_on_powerup),
        .selftest_on_shutdown(selftest_on_shutdown), .activity_enable_in(activity_enable_in),
        .sleep_in_n(sleep_in_n), .fast_fault_in(fast_fault_in), .fast_fault_filter_setting(fast_fault_filter_setting),
        .other_fault_in(other_fault_in), .reset_map(reset_map), .reset_delay_sel(reset_delay_sel),
        .irq_clear(irq_clear), .scl_in(scl_line), .sda_in(sda_line), .scl_filt(scl_filt), .sda_filt(sda_filt),
        .bus_enable(bus_enable), .ready(ready), .selftest_busy(selftest_busy), .monitor_active(monitor_active),
        .fast_fault_filt(fast_fault_filt), .sequence_stamp(sequence_stamp), .fault_irq_out_n(fault_irq_out_n),
        .fault_irq_oe(fault_irq_oe), .sys_reset_out_n(sys_reset_out_n), .sys_reset_oe(sys_reset_oe));
    host_bus_model u_host_bus_model (.scl_line(scl_line), .sda_line(sda_line));

    // Clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            n_fail++;
            test_done();
        end
    end
    // Bits captured on filtered clock rises; data drops counted
    always @(posedge scl_filt) begin
        sh = {sh[8:0], sda_filt};
        edges++;
    end
    always @(negedge sda_filt) drops++;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Edges from release to ready, by power-up test choice
    function automatic int exp_ready(input logic p);
        return LOAD + (p ? TEST : 0);
    endfunction : exp_ready

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd) begin
            n_fail++;
            $display("wrong value at %0t ns: seen %h expected %h", $time, seen, expd);
        end
    endtask : check
    task automatic test_done;
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
    endtask : cycles
    // Reset hold, reset values, then time the climb to ready
    task automatic startup(input logic p);
        logic busy_seen;
        busy_seen = 1'b0;
        @(posedge clk);
        selftest_on_powerup <= p;
        reset_n <= 1'b0;
        cycles(2);
        #1;
        check({ready, bus_enable, selftest_busy, sys_reset_out_n, fault_irq_out_n, scl_filt, sda_filt}, 7'h07);
        check(sequence_stamp, 0);
        @(posedge clk);
        reset_n <= 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            busy_seen |= selftest_busy;
            n++;
        end
        check(busy_seen, p);
        check(n >= exp_ready(p) && n <= exp_ready(p) + 2, 1);
        check(bus_enable, 1);
    endtask : startup
    // Wait for the interrupt output to fall, counting edges
    task automatic wait_irq;
        n = 0;
        while (fault_irq_out_n !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_irq
    task automatic pulse_clear;
        @(posedge clk);
        irq_clear <= 1'b1;
        @(posedge clk);
        irq_clear <= 1'b0;
        cycles(3);
        #1;
    endtask : pulse_clear

    initial begin
        startup(1'b0);
        startup(1'b1);
        // One bus byte, then a spike that must not pass
        rnd = lfsr(rnd);
        edges = 0;
        u_host_bus_model.send_byte(rnd[7:0]);
        cycles(5);
        check(edges, 10);
        check(sh, {rnd[7:0], 2'b10});
        n = drops;
        u_host_bus_model.spike();
        cycles(10);
        check(drops, n);
        // Activity edge: monitoring latency and stamp steps
        @(posedge clk);
        activity_enable_in <= 1'b1;
        n = 0;
        while (monitor_active !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n >= 1 && n <= supervisor_fault_timing_pkg::MON_ACT_CYC, 1);
        cycles(1250 - n);
        #1;
        check(sequence_stamp, 2);
        @(posedge clk);
        sleep_in_n <= 1'b0;
        cycles(10);
        #1;
        check(sequence_stamp, 0);
        // Fast faults: random channel, code, map; code 0 first
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr(rnd);
            ch = rnd[2:0];
            code = (k == 0) ? 10'h000 : {6'h00, rnd[6:3]} + 10'h001;
            @(posedge clk);
            fast_fault_filter_setting <= {8{code}};
            reset_map <= rnd[15:8];
            if (code != 0) begin
                fast_fault_in <= 8'h01 << ch;
                cycles(code);
                fast_fault_in <= 8'h00;
                cycles(8);
                #1;
                check({fast_fault_filt, fault_irq_out_n}, 9'h001);
                @(posedge clk);
            end
            fast_fault_in <= 8'h01 << ch;
            wait_irq();
            check(n >= code + 2 && n <= code + 6, 1);
            if (k == 0) check(n <= 6, 1);
            check(fast_fault_filt, 8'h01 << ch);
            check(sys_reset_out_n, !rnd[8 + ch]);
            @(posedge clk);
            fast_fault_in <= 8'h00;
            cycles(40);
            pulse_clear();
        end
        // Other fault, each delay code, with a restart mid-count
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            reset_delay_sel <= s[2:0];
            other_fault_in <= 1'b1;
            wait_irq();
            check(n <= supervisor_fault_timing_pkg::FAULT_LAT_CYC, 1);
            check({sys_reset_out_n, sys_reset_oe, fault_irq_oe}, 3'h3);
            pulse_clear();
            check(fault_irq_out_n, 0);
            @(posedge clk);
            other_fault_in <= 1'b0;
            cycles(DLY[s] / 2);
            other_fault_in <= 1'b1;
            cycles(3);
            other_fault_in <= 1'b0;
            n = 0;
            while (sys_reset_out_n !== 1'b1 && n < 300) begin
                @(posedge clk);
                #1;
                n++;
            end
            check(n >= DLY[s] && n <= DLY[s] + 6, 1);
            pulse_clear();
            check(fault_irq_out_n, 1);
        end
        // Shutdown self-test on activity fall
        @(posedge clk);
        selftest_on_shutdown <= 1'b1;
        activity_enable_in <= 1'b0;
        cycles(6);
        #1;
        check({selftest_busy, ready}, 2'h2);
        n = 0;
        while (ready !== 1'b1 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n <= TEST, 1);
        check(bus_enable, 1);
        test_done();
    end
endmodule : supervisor_fault_timing_test
`default_nettype wire
